/* File: auto_mute_dither_config.sv */
`include "auto_mute_defs.svh"
// What this block does
// - Link bit 0: each channel auto mutes on its own zero detection.
// - Link bit 1: mute both only when both would mute; resets to 1.
// - Zero detection length comes from a separate register input.
// - Bit 1 enables right channel auto mute when 1; resets to 1.
// - Bit 0 enables left channel auto mute when 1; resets to 1.
// - Linked and one channel disabled: the other never auto mutes.
// - Analog mute waits a programmed delay after complete digital mute.
// - Delay is eight-bit frame-period count, 0 none, reset 0x0C.
// - Left AC gain code 00 is 0.125, 01 is 0.25; resets zero.
// - Right AC gain code 00 is 0.125, 01 is 0.25; resets zero.
// - Left DEM gain code 00 is 0.5, 01 is 1.0; resets zero.
// - Right DEM gain code 00 is 0.5, 01 is 1.0; resets zero.
module auto_mute_dither_config #(
    parameter int ZLEN_W = 16                  // Zero length counter width
) (
    input  wire logic                      mclk,        // 20 MHz clock
    input  wire logic                      rstn,        // Sync reset, low
    input  wire logic [7:0]                reg_addr,    // Register offset
    input  wire logic [7:0]                reg_wdata,   // Write data
    input  wire logic                      reg_wr,      // Write strobe
    input  wire logic                      reg_rd,      // Read strobe
    output auto_mute_pkg::reg_byte_t       reg_rdata,   // Read data
    input  wire logic                      frame_tick,  // One per LR frame
    input  wire logic                      left_zero,   // Left sample zero
    input  wire logic                      right_zero,  // Right sample zero
    input  wire logic [ZLEN_W-1:0]         zero_len,    // Zero frames needed
    input  wire logic                      dig_mute_done, // Digital muted
    output logic                           left_auto_mute,  // Left muted
    output logic                           right_auto_mute, // Right muted
    output logic                           analog_silence,  // Analog mute
    output auto_mute_pkg::gain_t           left_primary_ac_gain,   // Q1.3
    output auto_mute_pkg::gain_t           right_primary_ac_gain,  // Q1.3
    output auto_mute_pkg::gain_t           left_primary_dem_gain,  // Q1.3
    output auto_mute_pkg::gain_t           right_primary_dem_gain  // Q1.3
);

    auto_mute_pkg::reg_byte_t ctrl_r;
    auto_mute_pkg::reg_byte_t delay_r;
    auto_mute_pkg::reg_byte_t gain_r;
    logic [ZLEN_W-1:0]        zcnt_r [2];
    logic [1:0]               zdone;
    logic [7:0]               wait_r;
    logic                     channel_link_mute_ctrl;
    logic                     mute_enable_bit1;
    logic                     mute_enable_bit0;

    assign channel_link_mute_ctrl = ctrl_r[`BIT_LINK_CTRL];
    assign mute_enable_bit1       = ctrl_r[`BIT_ENABLE1];
    assign mute_enable_bit0       = ctrl_r[`BIT_ENABLE0];

    // Register writes; reserved bits are stored as plain R/W
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_r  <= `RST_AUTO_MUTE_CTRL;
            delay_r <= `RST_ANALOG_DELAY;
            gain_r  <= `RST_DITHER_GAIN;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_AUTO_MUTE_CTRL: ctrl_r  <= reg_wdata;
                `OFS_ANALOG_DELAY:   delay_r <= reg_wdata;
                `OFS_DITHER_GAIN:    gain_r  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= `RST_BYTE_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_AUTO_MUTE_CTRL: reg_rdata <= ctrl_r;
                `OFS_ANALOG_DELAY:   reg_rdata <= delay_r;
                `OFS_DITHER_GAIN:    reg_rdata <= gain_r;
                default:             reg_rdata <= `RST_BYTE_ZERO;
            endcase
        end
    end

    // Consecutive zero frames per channel, index 0 left, 1 right
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                zcnt_r[i] <= '0;
            end
        end else if (frame_tick) begin
            for (int i = 0; i < 2; i++) begin
                if (!(i == 0 ? left_zero : right_zero)) begin
                    zcnt_r[i] <= '0;
                end else if (zcnt_r[i] != '1) begin
                    zcnt_r[i] <= zcnt_r[i] + 1'b1;
                end
            end
        end
    end

    // Length is owned by another register, not by this bank
    assign zdone[0] = zcnt_r[0] >= zero_len;
    assign zdone[1] = zcnt_r[1] >= zero_len;

    // Enable bits follow the described channel, not their names
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            left_auto_mute  <= 1'b0;
            right_auto_mute <= 1'b0;
        end else if (channel_link_mute_ctrl) begin
            left_auto_mute  <= mute_enable_bit0 && mute_enable_bit1 &&
                               zdone[0] && zdone[1];
            right_auto_mute <= mute_enable_bit0 && mute_enable_bit1 &&
                               zdone[0] && zdone[1];
        end else begin
            left_auto_mute  <= mute_enable_bit0 && zdone[0];
            right_auto_mute <= mute_enable_bit1 && zdone[1];
        end
    end

    // Frame periods elapsed since digital mute completed
    always_ff @(posedge mclk) begin
        if (!rstn || !dig_mute_done) begin
            wait_r <= `RST_BYTE_ZERO;
        end else if (frame_tick && wait_r != `WAIT_MAX) begin
            wait_r <= wait_r + 8'h01;
        end
    end

    // Release is immediate so unmuted audio is never clipped at the start
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            analog_silence <= 1'b0;
        end else begin
            analog_silence <= dig_mute_done && (wait_r >= delay_r);
        end
    end

    function automatic auto_mute_pkg::gain_t ac_gain(input logic [1:0] c);
        unique case (c)
            `CODE_00: ac_gain = `GAIN_0125;
            `CODE_01: ac_gain = `GAIN_025;
            `CODE_10: ac_gain = `GAIN_05;
            `CODE_11: ac_gain = `GAIN_NONE;
        endcase
    endfunction

    // Reserved DEM codes are not expected; they fall back to 0.5
    function automatic auto_mute_pkg::gain_t dem_gain(input logic [1:0] c);
        dem_gain = (c == `CODE_01) ? `GAIN_10 : `GAIN_05;
    endfunction

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            left_primary_ac_gain   <= `GAIN_0125;
            right_primary_ac_gain  <= `GAIN_0125;
            left_primary_dem_gain  <= `GAIN_05;
            right_primary_dem_gain <= `GAIN_05;
        end else begin
            left_primary_ac_gain   <= ac_gain(gain_r[`FLD_LEFT_AC]);
            right_primary_ac_gain  <= ac_gain(gain_r[`FLD_RIGHT_AC]);
            left_primary_dem_gain  <= dem_gain(gain_r[`FLD_LEFT_DEM]);
            right_primary_dem_gain <= dem_gain(gain_r[`FLD_RIGHT_DEM]);
        end
    end

    sequence s_mute_settled;
        dig_mute_done && $stable(delay_r) && delay_r == `RST_BYTE_ZERO;
    endsequence

    chk_reset_values: assert property (@(posedge mclk)
        !rstn |=> ctrl_r == `RST_AUTO_MUTE_CTRL &&
                  delay_r == `RST_ANALOG_DELAY && gain_r == `RST_DITHER_GAIN)
        else $error("register reset value wrong");

    chk_indep_left: assert property (@(posedge mclk) disable iff (!rstn)
        !channel_link_mute_ctrl && mute_enable_bit0 && zdone[0]
        |=> left_auto_mute)
        else $error("independent left auto mute missed");

    chk_indep_right: assert property (@(posedge mclk) disable iff (!rstn)
        !channel_link_mute_ctrl && !mute_enable_bit1 |=> !right_auto_mute)
        else $error("right auto mute while disabled");

    chk_linked_pair: assert property (@(posedge mclk) disable iff (!rstn)
        channel_link_mute_ctrl && !(zdone[0] && zdone[1])
        |=> !left_auto_mute && !right_auto_mute)
        else $error("linked auto mute with one channel live");

    chk_linked_disable: assert property (@(posedge mclk)
        disable iff (!rstn)
        channel_link_mute_ctrl && !(mute_enable_bit0 && mute_enable_bit1)
        |=> !left_auto_mute && !right_auto_mute)
        else $error("linked mute despite disabled channel");

    chk_zero_length: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(left_auto_mute) |-> $past(zcnt_r[0]) >= $past(zero_len))
        else $error("left muted before zero length reached");

    chk_delay_min: assert property (@(posedge mclk)
        disable iff (!rstn)
        analog_silence |-> $past(dig_mute_done) &&
                           $past(wait_r) >= $past(delay_r))
        else $error("analog mute before delay elapsed");

    chk_delay_zero: assert property (@(posedge mclk) disable iff (!rstn)
        s_mute_settled |=> analog_silence)
        else $error("zero delay did not mute at once");

    chk_ac_decode: assert property (@(posedge mclk)
        disable iff (!rstn)
        gain_r[`FLD_LEFT_AC] == `CODE_11 ##1 gain_r[`FLD_LEFT_AC] == `CODE_11
        |-> left_primary_ac_gain == `GAIN_NONE)
        else $error("left AC code 11 did not disable dither");

    chk_ac_right: assert property (@(posedge mclk)
        disable iff (!rstn)
        gain_r[`FLD_RIGHT_AC] == `CODE_01
        |=> right_primary_ac_gain == `GAIN_025)
        else $error("right AC gain decode wrong");

    chk_dem_decode: assert property (@(posedge mclk)
        disable iff (!rstn)
        gain_r[`FLD_LEFT_DEM] == `CODE_01 && gain_r[`FLD_RIGHT_DEM] == `CODE_00
        |=> left_primary_dem_gain == `GAIN_10 &&
            right_primary_dem_gain == `GAIN_05)
        else $error("DEM gain decode wrong");

endmodule // auto_mute_dither_config

/* File: auto_mute_defs.svh */
`ifndef AUTO_MUTE_DEFS_SVH
`define AUTO_MUTE_DEFS_SVH

// Register offsets
`define OFS_AUTO_MUTE_CTRL   8'h41
`define OFS_ANALOG_DELAY     8'h42
`define OFS_DITHER_GAIN      8'h43

// Reset values
`define RST_AUTO_MUTE_CTRL   8'h07
`define RST_ANALOG_DELAY     8'h0C
`define RST_DITHER_GAIN      8'h00
`define RST_BYTE_ZERO        8'h00

// Field positions in auto_mute_control
`define BIT_LINK_CTRL        2
`define BIT_ENABLE1          1
`define BIT_ENABLE0          0

// Field positions in primary_dither_gain
`define FLD_LEFT_AC          7:6
`define FLD_RIGHT_AC         5:4
`define FLD_LEFT_DEM         3:2
`define FLD_RIGHT_DEM        1:0

// Gain codes
`define CODE_00              2'h0
`define CODE_01              2'h1
`define CODE_10              2'h2
`define CODE_11              2'h3

// Gains as unsigned Q1.3
`define GAIN_NONE            4'h0
`define GAIN_0125            4'h1
`define GAIN_025             4'h2
`define GAIN_05              4'h4
`define GAIN_10              4'h8

// Saturation value of the frame-period wait counter
`define WAIT_MAX             8'hFF

`endif

/* File: auto_mute_pkg.sv */
package auto_mute_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] gain_t;
endpackage

/* File: testbench.sv */
`include "auto_mute_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      mclk = 1'b0;
    logic                      rstn = 1'b0;
    logic [7:0]                reg_addr = 8'h00;
    logic [7:0]                reg_wdata = 8'h00;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    auto_mute_pkg::reg_byte_t  reg_rdata;
    logic                      frame_tick = 1'b0;
    logic                      left_zero = 1'b0;
    logic                      right_zero = 1'b0;
    logic [15:0]               zero_len = 16'h0002;
    logic                      dig_mute_done = 1'b0;
    logic                      l_mute;
    logic                      r_mute;
    logic                      silence;
    auto_mute_pkg::gain_t      lac, rac, ldem, rdem;
    int                        num_errors = 0;
    int                        n_checks = 0;
    auto_mute_pkg::gain_t      ac_exp [4] = '{`GAIN_0125, `GAIN_025,
                                              `GAIN_05, `GAIN_NONE};

    always #25 mclk = ~mclk;

    auto_mute_dither_config #(.ZLEN_W(16)) DUT (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_tick(frame_tick),
        .left_zero(left_zero), .right_zero(right_zero),
        .zero_len(zero_len), .dig_mute_done(dig_mute_done),
        .left_auto_mute(l_mute), .right_auto_mute(r_mute),
        .analog_silence(silence), .left_primary_ac_gain(lac),
        .right_primary_ac_gain(rac), .left_primary_dem_gain(ldem),
        .right_primary_dem_gain(rdem));

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
        // Let an edge pass with the strobe low so a following read raises it afresh
        cyc(1);
    endtask

    // Frame ticks are single-cycle pulses with a gap, as the frame clock is
    // far slower than mclk
    task automatic tick(input int n);
        repeat (n) begin
            frame_tick = 1'b1;
            cyc(1);
            frame_tick = 1'b0;
            cyc(1);
        end
    endtask

    task automatic mutes(input logic el, input logic er);
        cyc(3);
        chk({7'h00, l_mute}, {7'h00, el});
        chk({7'h00, r_mute}, {7'h00, er});
    endtask

    task automatic gains(input logic [1:0] la, ra, input logic [3:0] ld, rd_);
        chk({4'h0, lac}, {4'h0, ac_exp[la]});
        chk({4'h0, rac}, {4'h0, ac_exp[ra]});
        chk({4'h0, ldem}, {4'h0, ld});
        chk({4'h0, rdem}, {4'h0, rd_});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        cyc(5);
        rstn = 1'b1;
        rd(`OFS_AUTO_MUTE_CTRL, `RST_AUTO_MUTE_CTRL);
        rd(`OFS_ANALOG_DELAY, `RST_ANALOG_DELAY);
        rd(`OFS_DITHER_GAIN, `RST_DITHER_GAIN);
        gains(2'h0, 2'h0, `GAIN_05, `GAIN_05);
        wr(8'h44, 8'hA5);
        rd(8'h44, `RST_BYTE_ZERO);
        $display("test reset done");
        // Left and right take opposite codes so a swapped field shows up
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_DITHER_GAIN, {c[1:0], 2'(3 - c), 1'b0, c[0], 1'b0, ~c[0]});
            cyc(1);
            gains(c[1:0], 2'(3 - c), c[0] ? `GAIN_10 : `GAIN_05,
                  c[0] ? `GAIN_05 : `GAIN_10);
        end
        $display("test gains done");
        wr(`OFS_AUTO_MUTE_CTRL, 8'h03);
        left_zero = 1'b1;
        tick(1);
        mutes(1'b0, 1'b0);
        tick(1);
        mutes(1'b1, 1'b0);
        wr(`OFS_AUTO_MUTE_CTRL, 8'h02);
        right_zero = 1'b1;
        tick(2);
        mutes(1'b0, 1'b1);
        wr(`OFS_AUTO_MUTE_CTRL, 8'h01);
        mutes(1'b1, 1'b0);
        wr(`OFS_AUTO_MUTE_CTRL, 8'h07);
        mutes(1'b1, 1'b1);
        right_zero = 1'b0;
        tick(1);
        mutes(1'b0, 1'b0);
        right_zero = 1'b1;
        tick(2);
        mutes(1'b1, 1'b1);
        wr(`OFS_AUTO_MUTE_CTRL, 8'h06);
        mutes(1'b0, 1'b0);
        wr(`OFS_AUTO_MUTE_CTRL, 8'h05);
        mutes(1'b0, 1'b0);
        wr(`OFS_AUTO_MUTE_CTRL, 8'hFF);
        rd(`OFS_AUTO_MUTE_CTRL, 8'hFF);
        zero_len = 16'h0010;
        mutes(1'b0, 1'b0);
        zero_len = 16'h0000;
        mutes(1'b1, 1'b1);
        $display("test auto mute done");
        wr(`OFS_ANALOG_DELAY, 8'h03);
        dig_mute_done = 1'b1;
        tick(2);
        cyc(3);
        chk({7'h00, silence}, 8'h00);
        tick(1);
        cyc(2);
        chk({7'h00, silence}, 8'h01);
        dig_mute_done = 1'b0;
        cyc(2);
        chk({7'h00, silence}, 8'h00);
        wr(`OFS_ANALOG_DELAY, 8'h00);
        dig_mute_done = 1'b1;
        cyc(2);
        chk({7'h00, silence}, 8'h01);
        dig_mute_done = 1'b0;
        wr(`OFS_ANALOG_DELAY, `WAIT_MAX);
        rd(`OFS_ANALOG_DELAY, `WAIT_MAX);
        dig_mute_done = 1'b1;
        tick(254);
        cyc(3);
        chk({7'h00, silence}, 8'h00);
        tick(1);
        cyc(2);
        chk({7'h00, silence}, 8'h01);
        $display("test analog mute done");
        results();
    end

    // About 630 cycles are needed; allow a wide margin
    initial begin
        #(4000 * 50);
        num_errors++;
        results();
    end
endmodule // testbench
